// ==== hw/dsi_lane_pkg.sv ====
// Purpose: Shared constants and types for the display link lane logic
// Assumes: Lane pair codes are formed as {positive line, negative line}
// Notes:   Lane index 4 is the clock pair, 3..0 are the data pairs
package dsi_lane_pkg;

  // ****************************************************************
  // Lane layout and fixed codes
  // ****************************************************************
  localparam int         N_DATA        = 4;
  localparam int         N_LANES       = 5;
  localparam int         CLK_LANE      = 4;     // Clock pair index
  localparam int         PIN_SYNC_W    = 14;    // Mode pins plus lines
  localparam logic [3:0] MODE_PINS_DSI = 4'hf;  // All mode pins high
  localparam logic [7:0] HS_SYNC_BYTE  = 8'h1d; // Leader seen on lane
  localparam logic [7:0] ESC_CMD_LPDT  = 8'he1;
  localparam logic [7:0] ESC_CMD_ULPS  = 8'h1e;
  localparam logic [7:0] ESC_CMD_RAR   = 8'h62;
  localparam logic [3:0] ESC_CMD_BITS  = 4'h8;  // Bits per entry command
  localparam logic [2:0] HS_LAST_BIT   = 3'h7;  // Last bit of a byte
  localparam logic [7:0] ESC_CMD_RST   = 8'h00;
  localparam logic [4:0] HS_RX_EN_RST  = 5'h00; // All receivers off

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  // Single-ended pair levels, {p, n}
  typedef enum logic [1:0] {
    LP_00 = 2'h0,   // Bridge / space
    LP_01 = 2'h1,   // HS request / mark-0, also HS-0 levels
    LP_10 = 2'h2,   // LP request / mark-1, also HS-1 levels
    LP_11 = 2'h3    // Stop
  } lp_code_t;

  // Clock lane power modes
  typedef enum logic [1:0] {
    low_power_clock_mode       = 2'h0,
    ultra_low_power_clock_mode = 2'h1,
    high_speed_clock_mode      = 2'h2
  } clock_mode_t;

  // Clock lane states, Gray along stop-request-settle-clocking
  typedef enum logic [2:0] {
    CK_STOP        = 3'h0,
    CK_HS_REQ      = 3'h1,
    CK_HS_SETTLE   = 3'h3,
    CK_HS_CLOCKING = 3'h2,
    CK_ULP_REQ     = 3'h4,
    CK_ULP_HOLD    = 3'h5,
    CK_ULP_EXIT    = 3'h7,
    CK_WAIT_STOP   = 3'h6
  } clk_st_t;

  // Data lane states, Gray along the burst and escape paths
  typedef enum logic [3:0] {
    DL_STOP      = 4'h0,
    DL_HS_REQ    = 4'h1,
    DL_HS_SETTLE = 4'h3,
    DL_HS_BURST  = 4'h2,
    DL_LP_REQ    = 4'h4,
    DL_BRIDGE    = 4'hc,
    DL_ESC_ENTRY = 4'hd,
    DL_ESCAPE    = 4'hf,
    DL_WAIT_STOP = 4'h8
  } dat_st_t;

  // Pair two sampled lines into a lane code
  function automatic lp_code_t lp_pair(input logic p, input logic n);
    return lp_code_t'({p, n});
  endfunction

endpackage

// ==== hw/dsi_lane_state_control.sv ====
// Purpose: Lane level receive control for the serial display link
// Assumes: Line levels come from the single-ended receivers, bits from
//          the differential receivers clocked by the link clock
// Notes:   Core runs on clock_in, bit capture on link_clk_in
`timescale 1ns/1ps
`default_nettype none
module dsi_lane_state_control
  import dsi_lane_pkg::*;
(
  input  wire logic               clock_in,
  input  wire logic               rst_n_in,
  input  wire logic               link_clk_in,
  input  wire logic               sw_reset_in,
  input  wire logic [3:0]         interface_mode_pins_in,
  input  wire logic [N_LANES-1:0] lane_lp_p_in,
  input  wire logic [N_LANES-1:0] lane_lp_n_in,
  input  wire logic [N_DATA-1:0]  hs_bit_in,
  output logic                    dsi_selected_out,
  output clock_mode_t             clock_mode_out,
  output logic      [N_LANES-1:0] hs_rx_en_out,
  output logic      [N_DATA-1:0]  dat_ulps_out,
  output logic      [7:0]         esc_cmd_out,
  output logic                    esc_cmd_valid_out,
  output logic                    remote_reset_out,
  output logic                    seq_error_out,
  output logic      [31:0]        hs_word_out,
  output logic                    hs_word_valid_out
);

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed {
    clk_st_t                clk_st;
    clock_mode_t            mode;
    dat_st_t [N_DATA-1:0]   dat_st;
    logic [N_DATA-1:0][7:0] esc_sh;
    logic [N_DATA-1:0][3:0] esc_cnt;
    logic [N_DATA-1:0]      esc_mark;
    logic [N_DATA-1:0]      esc_armed;
    logic [N_DATA-1:0]      ulps;
    logic [N_LANES-1:0]     hs_rx_en;
    logic                   sel;
    logic [7:0]             esc_cmd;
    logic                   esc_cmd_valid;
    logic                   remote_reset;
    logic                   seq_err;
    logic                   tog_d;
    logic [31:0]            hs_word;
    logic                   hs_word_valid;
  } core_t;

  typedef struct packed {
    logic [N_DATA-1:0][7:0] sh;
    logic                   aligned;
    logic [2:0]             bit_cnt;
    logic [31:0]            word;
    logic                   tog;
  } link_t;

  core_t                   r;
  core_t                   n;
  link_t                   lr;
  link_t                   ln;
  logic [PIN_SYNC_W-1:0]   pin_s;
  logic [N_DATA-1:0]       hs_en_lk;
  logic                    tog_s;

  // ****************************************************************
  // Crossings and pair decoding
  // ****************************************************************
  // Mode pins and line levels come from pins
  two_stage_sync #(.WIDTH(PIN_SYNC_W)) u_pin_sync (
    .clk_in   (clock_in),
    .rst_n_in (rst_n_in),
    .async_in ({interface_mode_pins_in, lane_lp_p_in, lane_lp_n_in}),
    .sync_out (pin_s)
  );

  // Data lane receive enables into the link domain
  two_stage_sync #(.WIDTH(N_DATA)) u_hs_en_sync (
    .clk_in   (link_clk_in),
    .rst_n_in (rst_n_in),
    .async_in (r.hs_rx_en[N_DATA-1:0]),
    .sync_out (hs_en_lk)
  );

  // Word-ready toggle back into the core domain
  two_stage_sync #(.WIDTH(1)) u_tog_sync (
    .clk_in   (clock_in),
    .rst_n_in (rst_n_in),
    .async_in (lr.tog),
    .sync_out (tog_s)
  );

  lane_code_if u_codes ();

  // Hand synchronised levels to the decoder
  assign u_codes.lp_p = pin_s[2*N_LANES-1:N_LANES];
  assign u_codes.lp_n = pin_s[N_LANES-1:0];

  lp_pair_decode u_decode (
    .lanes (u_codes.dec)
  );

  // ****************************************************************
  // Core next state
  // ****************************************************************
  // Clock lane modes, data lane states, escape decoding, word capture
  always_comb begin
    lp_code_t ck;
    lp_code_t d;
    logic     err;
    ck = u_codes.code[CLK_LANE];
    d = LP_11;
    err = 1'b0;
    n = r;
    n.esc_cmd_valid = 1'b0;
    n.remote_reset = 1'b0;
    n.hs_word_valid = 1'b0;
    // Link only works when every mode pin is high
    n.sel = (pin_s[PIN_SYNC_W-1:2*N_LANES] == MODE_PINS_DSI);

    // Clock lane: receive only, no escape beyond ultra-low
    if (!r.sel || sw_reset_in) begin
      n.clk_st = CK_STOP;
    end else if (ck == LP_11) begin
      n.clk_st = CK_STOP;
    end else begin
      case (r.clk_st)
        CK_STOP: begin
          if (ck == LP_01) begin
            n.clk_st = CK_HS_REQ;
          end else if (ck == LP_10) begin
            n.clk_st = CK_ULP_REQ;
          end else begin
            n.clk_st = CK_WAIT_STOP;
            err = 1'b1;
          end
        end
        CK_HS_REQ: begin
          if (ck == LP_00) begin
            n.clk_st = CK_HS_SETTLE;
          end else if (ck == LP_10) begin
            n.clk_st = CK_WAIT_STOP;
            err = 1'b1;
          end
        end
        CK_HS_SETTLE: begin
          // Differential swing reads as LP-00 on the line receivers
          if (ck == LP_00) begin
            n.clk_st = CK_HS_CLOCKING;
          end
        end
        CK_HS_CLOCKING: begin
          // Hold while LP-00, only LP-11, deselect or soft reset end clocking
          n.clk_st = CK_HS_CLOCKING;
        end
        CK_ULP_REQ: begin
          if (ck == LP_00) begin
            n.clk_st = CK_ULP_HOLD;
          end else if (ck == LP_01) begin
            n.clk_st = CK_WAIT_STOP;
            err = 1'b1;
          end
        end
        CK_ULP_HOLD: begin
          if (ck == LP_10) begin
            n.clk_st = CK_ULP_EXIT;
          end else if (ck == LP_01) begin
            n.clk_st = CK_WAIT_STOP;
            err = 1'b1;
          end
        end
        CK_ULP_EXIT: begin
          if (ck == LP_00) begin
            n.clk_st = CK_ULP_HOLD;
          end else if (ck == LP_01) begin
            n.clk_st = CK_WAIT_STOP;
            err = 1'b1;
          end
        end
        CK_WAIT_STOP: begin
          n.clk_st = CK_WAIT_STOP;
        end
        default: begin
          n.clk_st = CK_STOP;
        end
      endcase
    end

    // Power mode seen by the rest of the chip
    case (n.clk_st)
      CK_HS_SETTLE, CK_HS_CLOCKING: n.mode = high_speed_clock_mode;
      CK_ULP_HOLD, CK_ULP_EXIT:     n.mode = ultra_low_power_clock_mode;
      default:                      n.mode = low_power_clock_mode;
    endcase
    n.hs_rx_en[CLK_LANE] = (n.mode == high_speed_clock_mode);

    // Data lanes: bursts forward, escape decoded from marks and spaces
    for (int i = 0; i < N_DATA; i++) begin
      d = u_codes.code[i];
      if (!r.sel || sw_reset_in || d == LP_11) begin
        n.dat_st[i] = DL_STOP;
        n.ulps[i] = 1'b0;
      end else begin
        case (r.dat_st[i])
          DL_STOP: begin
            if (d == LP_01) begin
              n.dat_st[i] = DL_HS_REQ;
            end else if (d == LP_10) begin
              n.dat_st[i] = DL_LP_REQ;
            end else begin
              n.dat_st[i] = DL_WAIT_STOP;
              err = 1'b1;
            end
          end
          DL_HS_REQ: begin
            // A burst needs the clock lane already clocking
            if (d == LP_00 && r.clk_st == CK_HS_CLOCKING) begin
              n.dat_st[i] = DL_HS_SETTLE;
            end else if (d != LP_01) begin
              n.dat_st[i] = DL_WAIT_STOP;
              err = 1'b1;
            end
          end
          DL_HS_SETTLE: begin
            if (d == LP_00) begin
              n.dat_st[i] = DL_HS_BURST;
            end
          end
          DL_HS_BURST: begin
            n.dat_st[i] = DL_HS_BURST;
          end
          DL_LP_REQ: begin
            if (d == LP_00) begin
              n.dat_st[i] = DL_BRIDGE;
            end else if (d == LP_01) begin
              n.dat_st[i] = DL_WAIT_STOP;
              err = 1'b1;
            end
          end
          DL_BRIDGE: begin
            // LP-10 here is a turnaround request, not served
            if (d == LP_01) begin
              n.dat_st[i] = DL_ESC_ENTRY;
            end else if (d == LP_10) begin
              n.dat_st[i] = DL_WAIT_STOP;
            end
          end
          DL_ESC_ENTRY: begin
            if (d == LP_00) begin
              n.dat_st[i] = DL_ESCAPE;
              n.esc_cnt[i] = 4'h0;
              n.esc_armed[i] = 1'b0;
              n.esc_sh[i] = 8'h00;
            end else if (d == LP_10) begin
              n.dat_st[i] = DL_WAIT_STOP;
              err = 1'b1;
            end
          end
          DL_ESCAPE: begin
            if (d != LP_00) begin
              // Mark-0 or mark-1 holds the pending bit
              n.esc_mark[i] = (d == LP_10);
              n.esc_armed[i] = 1'b1;
            end else if (r.esc_armed[i] &&
                         r.esc_cnt[i] != ESC_CMD_BITS) begin
              // Space after a mark commits one command bit
              n.esc_armed[i] = 1'b0;
              n.esc_sh[i] = {r.esc_sh[i][6:0], r.esc_mark[i]};
              n.esc_cnt[i] = r.esc_cnt[i] + 4'h1;
              if (n.esc_cnt[i] == ESC_CMD_BITS) begin
                n.ulps[i] = (n.esc_sh[i] == ESC_CMD_ULPS);
                if (i == 0) begin
                  n.esc_cmd = n.esc_sh[i];
                  n.esc_cmd_valid = 1'b1;
                  n.remote_reset = (n.esc_sh[i] == ESC_CMD_RAR);
                end
              end
            end
          end
          DL_WAIT_STOP: begin
            n.dat_st[i] = DL_WAIT_STOP;
          end
          default: begin
            n.dat_st[i] = DL_STOP;
          end
        endcase
      end
      n.hs_rx_en[i] = (n.dat_st[i] == DL_HS_SETTLE) ||
                      (n.dat_st[i] == DL_HS_BURST);
    end
    n.seq_err = err;

    // Take a finished word when the link toggle moves
    n.tog_d = tog_s;
    if (tog_s != r.tog_d) begin
      n.hs_word = lr.word;
      n.hs_word_valid = 1'b1;
    end
  end

  // Core state register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Link domain bit capture
  // ****************************************************************
  // Shift enabled lanes, lock on the leader, emit one word per byte
  always_comb begin
    ln = lr;
    for (int i = 0; i < N_DATA; i++) begin
      if (hs_en_lk[i]) begin
        ln.sh[i] = {lr.sh[i][6:0], hs_bit_in[i]};
      end
    end
    // Clock keeps running after the burst, so the drop is seen here
    if (!hs_en_lk[0]) begin
      ln.aligned = 1'b0;
      ln.bit_cnt = 3'h0;
    end else if (!lr.aligned) begin
      if (ln.sh[0] == HS_SYNC_BYTE) begin
        ln.aligned = 1'b1;
        ln.bit_cnt = 3'h0;
      end
    end else begin
      ln.bit_cnt = lr.bit_cnt + 3'h1;
      if (lr.bit_cnt == HS_LAST_BIT) begin
        ln.word = ln.sh;
        ln.tog = ~lr.tog;
      end
    end
  end

  // Link state register
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lr <= '0;
    end else begin
      lr <= ln;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign dsi_selected_out  = r.sel;
  assign clock_mode_out    = r.mode;
  assign hs_rx_en_out      = r.hs_rx_en;
  assign dat_ulps_out      = r.ulps;
  assign esc_cmd_out       = r.esc_cmd;
  assign esc_cmd_valid_out = r.esc_cmd_valid;
  assign remote_reset_out  = r.remote_reset;
  assign seq_error_out     = r.seq_err;
  assign hs_word_out       = r.hs_word;
  assign hs_word_valid_out = r.hs_word_valid;

endmodule
`default_nettype wire

// ==== hw/lane_code_if.sv ====
// Purpose: Carries synchronised line levels and decoded lane codes
// Assumes: Levels are already in the core clock domain
// Notes:   core drives levels, dec returns codes
`timescale 1ns/1ps
`default_nettype none
interface lane_code_if;
  import dsi_lane_pkg::*;
  logic [N_LANES-1:0]     lp_p;
  logic [N_LANES-1:0]     lp_n;
  lp_code_t [N_LANES-1:0] code;
  modport core (output lp_p, output lp_n, input code);
  modport dec  (input lp_p, input lp_n, output code);
endinterface
`default_nettype wire

// ==== hw/lp_pair_decode.sv ====
// Purpose: Turns each pair of sampled lines into a lane code
// Assumes: Inputs already synchronised
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module lp_pair_decode
  import dsi_lane_pkg::*;
(
  lane_code_if.dec lanes
);
  // Pair positive and negative line of every lane
  always_comb begin
    for (int i = 0; i < N_LANES; i++) begin
      lanes.code[i] = lp_pair(lanes.lp_p[i], lanes.lp_n[i]);
    end
  end
endmodule
`default_nettype wire

// ==== hw/two_stage_sync.sv ====
// Purpose: Two flip-flop synchroniser for levels
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module two_stage_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t r;
  sync_t n;

  // Shift the level through two stages
  always_comb begin
    n.meta   = async_in;
    n.stable = r.meta;
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.stable;
endmodule
`default_nettype wire

// ==== tb/host_lane_model.sv ====
// Purpose: Host transmitter model driving the lane lines
// Assumes: Levels change just after a core clock edge
// Notes:   Each level is held four core cycles
`timescale 1ns/1ps
`default_nettype none
module host_lane_model
  import dsi_lane_pkg::*;
(
  input  wire logic               clock_in,
  output logic      [N_LANES-1:0] lp_p_out,
  output logic      [N_LANES-1:0] lp_n_out,
  output logic      [N_DATA-1:0]  hs_bit_out,
  output logic                    link_clk_out
);
  logic run_r;

  // ********
  // Link clock
  // ********
  // Stops only when low, so every burst starts and ends in HS-0
  initial begin
    {lp_p_out, lp_n_out} = '1;
    hs_bit_out = '0;
    link_clk_out = 1'b0;
    run_r = 1'b0;
    #7;
    forever begin
      #16;
      if (run_r || link_clk_out) begin
        link_clk_out = ~link_clk_out;
      end
    end
  end

  // ********
  // Lane sequences
  // ********
  // Puts one pair code on the masked lanes
  task automatic lvl(input logic [N_LANES-1:0] m, input lp_code_t c);
    @(posedge clock_in);
    for (int i = 0; i < N_LANES; i++) begin
      if (m[i]) begin
        lp_p_out[i] <= c[1];
        lp_n_out[i] <= c[0];
      end
    end
    repeat (3) @(posedge clock_in);
  endtask

  // Clock lane into and out of high speed
  task automatic clk_hs_on();
    lvl(5'h10, LP_01);
    lvl(5'h10, LP_00);
    run_r = 1'b1;
  endtask

  task automatic clk_hs_off();
    run_r = 1'b0;
    repeat (2) @(posedge clock_in);
    lvl(5'h10, LP_11);
  endtask

  // Clock lane into ultra low power, or back out to stop
  task automatic clk_ulp(input logic on);
    lvl(5'h10, LP_10);
    lvl(5'h10, on ? LP_00 : LP_11);
  endtask

  // Escape entry on lane 0 and eight command bits
  task automatic esc(input logic [7:0] cmd);
    lvl(5'h01, LP_10);
    lvl(5'h01, LP_00);
    lvl(5'h01, LP_01);
    lvl(5'h01, LP_00);
    for (int b = 7; b >= 0; b--) begin
      lvl(5'h01, cmd[b] ? LP_10 : LP_01);
      lvl(5'h01, LP_00);
    end
  endtask

  // Data lanes: request, settle, leader on lane 0, one word
  task automatic hs_word(input logic [31:0] w);
    logic [23:0] lead;
    lead = {16'h0000, HS_SYNC_BYTE};
    lvl(5'h0f, LP_01);
    lvl(5'h0f, LP_00);
    for (int k = 0; k < 32; k++) begin
      @(posedge link_clk_out);
      for (int i = 0; i < N_DATA; i++) begin
        hs_bit_out[i] <= k < 24 ? (i == 0 && lead[23-k]) : w[8*i+31-k];
      end
    end
    lvl(5'h0f, LP_11);
  endtask
endmodule
`default_nettype wire

// ==== tb/lane_state_sva.sv ====
// Purpose: Concurrent checks on the lane control ports
// Assumes: All checks run in the core clock domain
// Notes:   Attached to the top module by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module lane_state_sva
  import dsi_lane_pkg::*;
(
  input wire logic               clock_in,
  input wire logic               rst_n_in,
  input wire logic               link_clk_in,
  input wire logic               sw_reset_in,
  input wire logic [3:0]         interface_mode_pins_in,
  input wire logic [N_LANES-1:0] lane_lp_p_in,
  input wire logic [N_LANES-1:0] lane_lp_n_in,
  input wire logic [N_DATA-1:0]  hs_bit_in,
  input wire logic               dsi_selected_out,
  input wire clock_mode_t        clock_mode_out,
  input wire logic [N_LANES-1:0] hs_rx_en_out,
  input wire logic [N_DATA-1:0]  dat_ulps_out,
  input wire logic [7:0]         esc_cmd_out,
  input wire logic               esc_cmd_valid_out,
  input wire logic               remote_reset_out,
  input wire logic               seq_error_out,
  input wire logic [31:0]        hs_word_out,
  input wire logic               hs_word_valid_out
);
  // Pair levels of the clock lane and data lane 0
  wire logic [1:0] ck_pair = {lane_lp_p_in[CLK_LANE], lane_lp_n_in[CLK_LANE]};
  wire logic [1:0] d0_pair = {lane_lp_p_in[0], lane_lp_n_in[0]};

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // ********
  // Assertions
  // ********
  property p_sel_on;
    (interface_mode_pins_in == MODE_PINS_DSI) [*4] |=> dsi_selected_out;
  endproperty
  a_sel_on: assert property (p_sel_on)
    else $error("link not selected");
  property p_sel_gate;
    !dsi_selected_out [*3] |-> clock_mode_out == low_power_clock_mode
      && hs_rx_en_out == HS_RX_EN_RST;
  endproperty
  a_sel_gate: assert property (p_sel_gate)
    else $error("lane active while deselected");
  property p_hs_term;
    clock_mode_out == high_speed_clock_mode |-> hs_rx_en_out[CLK_LANE];
  endproperty
  a_hs_term: assert property (p_hs_term)
    else $error("clock receiver off in high speed");
  property p_stop_clk;
    (ck_pair == LP_11) [*4] |=> clock_mode_out == low_power_clock_mode
      && !hs_rx_en_out[CLK_LANE];
  endproperty
  a_stop_clk: assert property (p_stop_clk)
    else $error("clock lane not stopped");
  property p_stop_dat;
    (d0_pair == LP_11) [*4] |=> !hs_rx_en_out[0] && !dat_ulps_out[0];
  endproperty
  a_stop_dat: assert property (p_stop_dat)
    else $error("data lane not stopped");
  property p_hs_entry;
    $rose(clock_mode_out == high_speed_clock_mode) |-> $past(ck_pair, 3) == LP_00;
  endproperty
  a_hs_entry: assert property (p_hs_entry)
    else $error("high speed without bridge");
  property p_ulp_entry;
    $rose(clock_mode_out == ultra_low_power_clock_mode)
      |-> $past(ck_pair, 3) == LP_00;
  endproperty
  a_ulp_entry: assert property (p_ulp_entry)
    else $error("ultra low without space");
  property p_ulp_exit;
    clock_mode_out == ultra_low_power_clock_mode
      |=> clock_mode_out != high_speed_clock_mode;
  endproperty
  a_ulp_exit: assert property (p_ulp_exit)
    else $error("ultra low left to high speed");
  property p_swrst;
    sw_reset_in [*2] |=> clock_mode_out == low_power_clock_mode
      && hs_rx_en_out == HS_RX_EN_RST && dat_ulps_out == 4'h0;
  endproperty
  a_swrst: assert property (p_swrst)
    else $error("soft reset left lanes active");
  property p_esc_pulse;
    esc_cmd_valid_out |=> !esc_cmd_valid_out;
  endproperty
  a_esc_pulse: assert property (p_esc_pulse)
    else $error("command valid held");

  // Main scenarios reached
  c_hs: cover property (clock_mode_out == high_speed_clock_mode);
  c_ulp: cover property (clock_mode_out == ultra_low_power_clock_mode);
  c_word: cover property (hs_word_valid_out);
endmodule

bind dsi_lane_state_control lane_state_sva chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
  .sw_reset_in(sw_reset_in), .interface_mode_pins_in(interface_mode_pins_in),
  .lane_lp_p_in(lane_lp_p_in), .lane_lp_n_in(lane_lp_n_in),
  .hs_bit_in(hs_bit_in), .dsi_selected_out(dsi_selected_out),
  .clock_mode_out(clock_mode_out), .hs_rx_en_out(hs_rx_en_out),
  .dat_ulps_out(dat_ulps_out), .esc_cmd_out(esc_cmd_out),
  .esc_cmd_valid_out(esc_cmd_valid_out),
  .remote_reset_out(remote_reset_out), .seq_error_out(seq_error_out),
  .hs_word_out(hs_word_out), .hs_word_valid_out(hs_word_valid_out)
);
`default_nettype wire

// ==== tb/test_dsi_lane_state_control.sv ====
// Purpose: Self-checking bench for the lane state control block
// Assumes: Host model drives all lane lines and the link clock
// Notes:   Expected words wait in a queue until the design answers
`timescale 1ns/1ps
`default_nettype none
module test_dsi_lane_state_control;
  import dsi_lane_pkg::*;
  logic                clock_in;
  logic                rst_n_in;
  logic                sw_reset_in;
  logic [3:0]          mode_pins;
  wire  [N_LANES-1:0]  lp_p;
  wire  [N_LANES-1:0]  lp_n;
  wire  [N_DATA-1:0]   hs_bit;
  wire                 link_clk;
  logic                sel;
  clock_mode_t         mode;
  logic [N_LANES-1:0]  rx_en;
  logic [N_DATA-1:0]   ulps;
  logic [7:0]          esc_cmd;
  logic                esc_vld;
  logic                rar;
  logic                seq_err;
  logic [31:0]         word;
  logic                word_vld;
  int                  miscompares;
  int                  n_checks;
  logic [31:0]         word_q[$];
  logic [7:0]          esc_seen;
  logic                rar_seen;
  logic                err_seen;
  logic [7:0]          cmds[4];
  logic [31:0]         w;

  dsi_lane_state_control dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk),
    .sw_reset_in(sw_reset_in), .interface_mode_pins_in(mode_pins),
    .lane_lp_p_in(lp_p), .lane_lp_n_in(lp_n), .hs_bit_in(hs_bit),
    .dsi_selected_out(sel), .clock_mode_out(mode), .hs_rx_en_out(rx_en),
    .dat_ulps_out(ulps), .esc_cmd_out(esc_cmd), .esc_cmd_valid_out(esc_vld),
    .remote_reset_out(rar), .seq_error_out(seq_err), .hs_word_out(word),
    .hs_word_valid_out(word_vld)
  );
  host_lane_model host (
    .clock_in(clock_in), .lp_p_out(lp_p), .lp_n_out(lp_n),
    .hs_bit_out(hs_bit), .link_clk_out(link_clk)
  );

  // ********
  // Helpers
  // ********
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
    @(negedge clock_in);
  endtask

  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Core clock, 40 ns
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Compares words and records escape results as they appear
  always @(posedge clock_in) begin
    if (word_vld === 1'b1 && word_q.size() > 0) begin
      check("hs_word", word_q.pop_front(), word);
    end
    if (esc_vld === 1'b1) begin
      esc_seen <= esc_cmd;
    end
    if (rar === 1'b1) begin
      rar_seen <= 1'b1;
    end
    if (seq_err === 1'b1) begin
      err_seen <= 1'b1;
    end
  end

  // Cuts a hang short
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    miscompares = 0;
    n_checks = 0;
    rst_n_in = 1'b0;
    sw_reset_in = 1'b0;
    mode_pins = MODE_PINS_DSI;
    rar_seen = 1'b0;
    err_seen = 1'b0;
    esc_seen = ESC_CMD_RST;
    void'($urandom(32'hc453));
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    wt(4);
    check("sel", 1, sel);
    check("mode", low_power_clock_mode, mode);
    check("rx_en", 0, rx_en);
    host.clk_ulp(1'b1);
    wt(1);
    check("mode", ultra_low_power_clock_mode, mode);
    check("rx_en", 0, rx_en);
    host.clk_ulp(1'b0);
    wt(1);
    check("mode", low_power_clock_mode, mode);
    @(posedge clock_in) mode_pins <= 4'($urandom_range(14, 0));
    wt(5);
    check("sel", 0, sel);
    host.clk_hs_on();
    wt(1);
    check("mode", low_power_clock_mode, mode);
    host.clk_hs_off();
    @(posedge clock_in) mode_pins <= MODE_PINS_DSI;
    wt(5);
    host.clk_hs_on();
    wt(1);
    check("mode", high_speed_clock_mode, mode);
    check("rx_en_clk", 1, rx_en[CLK_LANE]);
    w = $urandom;
    word_q.push_back(w);
    host.hs_word(w);
    wt(4);
    check("words_left", 0, word_q.size());
    check("rx_en_dat", 0, rx_en[N_DATA-1:0]);
    check("mode", high_speed_clock_mode, mode);
    host.clk_hs_off();
    wt(1);
    check("mode", low_power_clock_mode, mode);
    cmds = '{ESC_CMD_ULPS, ESC_CMD_RAR, ESC_CMD_LPDT, 8'($urandom)};
    foreach (cmds[j]) begin
      rar_seen = 1'b0;
      err_seen = 1'b0;
      host.esc(cmds[j]);
      wt(4);
      check("esc_cmd", cmds[j], esc_seen);
      check("rar", cmds[j] == ESC_CMD_RAR, rar_seen);
      check("ulps", cmds[j] == ESC_CMD_ULPS, ulps[0]);
      if (cmds[j] == ESC_CMD_ULPS) begin
        @(posedge clock_in) sw_reset_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        sw_reset_in <= 1'b0;
        wt(1);
        check("ulps", 0, ulps);
      end
      host.lvl(5'h01, LP_10);
      host.lvl(5'h01, LP_11);
      wt(1);
      check("ulps", 0, ulps);
      // Stop after soft reset sees space, an illegal step
      check("seq_err", cmds[j] == ESC_CMD_ULPS, err_seen);
    end
    stop_test();
  end
endmodule
`default_nettype wire
